// file: hw/floppy_host_rate_status_regs.sv
// host rate select, tape/media and main status registers of a floppy controller
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module floppy_host_rate_status_regs
  import floppy_host_rate_status_pkg::*;
(
  // clock and hardware reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // host register port
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  output logic      [7:0] rd_data_oe,
  // configuration from neighbouring logic
  input  wire logic       enhanced_mode,
  input  wire logic [7:0] config_reg_six,
  input  wire logic [7:0] config_reg_seven,
  input  wire logic [1:0] drive_select,
  input  wire logic       output_reset,
  input  wire logic       ccr_write,
  input  wire logic [1:0] ccr_rate,
  input  wire logic       configure_write,
  input  wire logic [7:0] configure_track,
  // command engine status
  input  wire logic [3:0] drive_seek_busy,
  input  wire logic       command_busy,
  input  wire logic       exec_phase,
  input  wire logic       non_dma_mode,
  input  wire logic       host_request,
  input  wire logic       transfer_direction,
  input  wire logic       data_reg_access,
  // two-way rate pins
  input  wire logic       rate_pin_0_in,
  output logic            rate_pin_0_out,
  output logic            rate_pin_0_oe,
  input  wire logic       rate_pin_1_in,
  output logic            rate_pin_1_out,
  output logic            rate_pin_1_oe,
  // controller outputs
  output logic      [1:0] data_rate,
  output logic      [2:0] write_select_a_steps,
  output logic      [7:0] write_select_a_start_track,
  output logic            low_power,
  output logic            soft_reset_out,
  output logic      [1:0] tape_select
);

  logic [2:0]   write_select_a;
  logic [1:0]   pin_meta;
  logic [1:0]   pin_sync;
  logic [1:0]   media_ident;
  logic         media_ident_hi;
  logic         media_ident_lo;
  logic [1:0]   drive_type;
  logic [7:0]   controller_status_reg;
  logic [7:0]   tape_media_id_reg;
  logic         wr_rate;
  logic         rd_rate;
  logic         rd_tape;
  logic         sw_reset_evt;
  power_state_e pwr_state;
  power_state_e next_pwr_state;

  // picks the precompensation delay that a code asks for
  function automatic logic [2:0] write_select_a_decode(
    input logic [2:0] code,
    input logic [1:0] rate
  );
    logic [2:0] steps;
    steps = code;
    if (code == WRITE_SELECT_A_DISABLED) begin
      steps = STEPS_NONE;
    end else if (code == WRITE_SELECT_A_DEFAULT) begin
      steps = (rate == RATE_1M) ? STEPS_DEF_1M : STEPS_DEF_SLOW;
    end
    return steps;
  endfunction

  // picks the cr6 bit pair belonging to a drive
  function automatic logic [1:0] drive_pair(
    input logic [7:0] cfg,
    input logic [1:0] drv
  );
    return cfg[{drv, 1'b0} +: 2];
  endfunction

  assign wr_rate = wr_en && (addr == RATE_STATUS_OFS);
  assign rd_rate = rd_en && (addr == RATE_STATUS_OFS);
  assign rd_tape = rd_en && (addr == TAPE_MEDIA_ID_OFS);

  // self clearing reset, shared with output reg
  assign sw_reset_evt = soft_reset_out || output_reset;

  // rate pins drive the rate only outside enhanced mode 2
  assign rate_pin_0_out = data_rate[0];
  assign rate_pin_1_out = data_rate[1];
  assign rate_pin_0_oe  = !enhanced_mode;
  assign rate_pin_1_oe  = !enhanced_mode;

  // media bits see pins only through a two-stage synchroniser; no reset on
  // purpose so neither reset disturbs what the pins report
  // reset free sampling
  always_ff @(posedge clk) begin
    pin_meta <= {rate_pin_1_in, rate_pin_0_in};
    pin_sync <= pin_meta;
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_media
      assign media_ident[i] = pin_sync[i] ^ config_reg_seven[CR7_INV_LSB + i];
    end
  endgenerate

  assign media_ident_hi = media_ident[1];
  assign media_ident_lo = media_ident[0];

  assign drive_type = drive_pair(config_reg_six, drive_select);

  // enhanced layout of the tape/media register
  assign tape_media_id_reg = {media_ident_hi, media_ident_lo, drive_type,
                              config_reg_seven[CR7_BOOT_LSB +: 2], tape_select};

  // busy bits, command busy, non-DMA execution, direction, request
  assign controller_status_reg = {host_request, transfer_direction,
                                  non_dma_mode && exec_phase,
                                  command_busy, drive_seek_busy};

  // tape select storage, kept over software reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tape_select <= 2'h0;
    end else if (wr_en && addr == TAPE_MEDIA_ID_OFS) begin
      tape_select <= wr_data[1:0];
    end
  end

  // latest writer wins; hardware reset gives 250K
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_rate <= RATE_SELECT_RESET[RATE_LSB +: 2];
    end else if (wr_rate) begin
      data_rate <= wr_data[RATE_LSB +: 2];
    end else if (ccr_write) begin
      data_rate <= ccr_rate;
    end
  end

  // write_select_a field untouched by software reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      write_select_a <= RATE_SELECT_RESET[WRITE_SELECT_A_LSB +: 3];
    end else if (wr_rate) begin
      write_select_a <= wr_data[WRITE_SELECT_A_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      write_select_a_steps <= STEPS_NONE;
    end else begin
      write_select_a_steps <= write_select_a_decode(write_select_a, data_rate);
    end
  end

  // start track, only the configure command moves it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      write_select_a_start_track <= START_TRACK_RESET;
    end else if (configure_write) begin
      write_select_a_start_track <= configure_track;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= wr_rate && wr_data[SOFT_RESET_BIT];
    end
  end

  // a soft reset bit in the same write takes priority over entering low power
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      PWR_RUN: begin
        if (wr_rate && wr_data[LOW_POWER_BIT] && !wr_data[SOFT_RESET_BIT]) begin
          next_pwr_state = PWR_LOW;
        end
      end
      PWR_LOW: begin
        if (sw_reset_evt || data_reg_access || rd_rate) begin
          next_pwr_state = PWR_RUN;
        end
      end
      default: next_pwr_state = PWR_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr_state <= PWR_RUN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  assign low_power = (pwr_state == PWR_LOW);

  // read data registered; bus lines with oe low float outside
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data    <= 8'h00;
      rd_data_oe <= OE_NONE;
    end else if (rd_rate) begin
      rd_data    <= controller_status_reg;
      rd_data_oe <= OE_ALL;
    end else if (rd_tape && enhanced_mode) begin
      rd_data    <= tape_media_id_reg;
      rd_data_oe <= OE_ALL;
    end else if (rd_tape) begin
      rd_data    <= {6'h00, tape_select};
      rd_data_oe <= TAPE_OE_NORMAL;
    end else begin
      rd_data    <= 8'h00;
      rd_data_oe <= OE_NONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_tape_normal_float: assert property (
    rd_tape && !enhanced_mode |=>
      rd_data_oe == TAPE_OE_NORMAL && rd_data[1:0] == $past(tape_select))
    else $error("normal tape read drove wrong lines");

  a_media_pins_read: assert property (
    rd_tape && enhanced_mode |=>
      rd_data[7:6] == ($past(pin_sync) ^ $past(config_reg_seven[3:2])))
    else $error("media bits do not follow rate pins");

  a_media_follows_pin: assert property (
    $stable(rate_pin_1_in) [*3] ##0 $stable(config_reg_seven[3]) |->
      media_ident_hi == (rate_pin_1_in ^ config_reg_seven[3]))
    else $error("media bit 7 inversion wrong");

  a_media_lo_follows: assert property (
    $stable(rate_pin_0_in) [*3] ##0 $stable(config_reg_seven[2]) |->
      media_ident_lo == (rate_pin_0_in ^ config_reg_seven[2]))
    else $error("media bit 6 inversion wrong");

  a_drive_type_pair: assert property (
    rd_tape && enhanced_mode |=>
      rd_data[5:4] == $past(config_reg_six[{drive_select, 1'b0} +: 2]))
    else $error("drive type pair wrong");

  a_boot_drive_bits: assert property (
    rd_tape && enhanced_mode |=> rd_data[3:2] == $past(config_reg_seven[1:0]))
    else $error("boot drive bits wrong");

  a_tape_write_read: assert property (
    wr_en && addr == TAPE_MEDIA_ID_OFS ##1 rd_tape |=>
      rd_data[1:0] == $past(wr_data[1:0], 2))
    else $error("tape select not stored");

  a_tape_select_hold: assert property (
    !(wr_en && addr == TAPE_MEDIA_ID_OFS) |=> $stable(tape_select))
    else $error("tape select changed without a write");

  a_rate_from_dsr: assert property (
    wr_rate |=> data_rate == $past(wr_data[1:0]))
    else $error("rate select write lost");

  a_rate_from_ccr: assert property (
    ccr_write && !wr_rate |=> data_rate == $past(ccr_rate))
    else $error("config control rate write lost");

  a_soft_keeps_rate: assert property (
    sw_reset_evt && !wr_rate && !ccr_write |=> $stable(data_rate))
    else $error("software reset changed rate");

  a_rate_hold: assert property (
    !wr_rate && !ccr_write |=> $stable(data_rate))
    else $error("rate changed without a write");

  // the release edge still samples reset state, so it is left out
  a_write_select_a_default: assert property (
    reset_n && $stable(write_select_a) && $stable(data_rate) &&
      write_select_a == WRITE_SELECT_A_DEFAULT |=>
      write_select_a_steps == ($past(data_rate) == RATE_1M ? STEPS_DEF_1M : STEPS_DEF_SLOW))
    else $error("default precompensation wrong");

  a_write_select_a_explicit: assert property (
    reset_n && write_select_a != WRITE_SELECT_A_DEFAULT |=>
      write_select_a_steps == ($past(write_select_a) == WRITE_SELECT_A_DISABLED ? STEPS_NONE :
                        $past(write_select_a)))
    else $error("explicit precompensation wrong");

  a_lowpower_exit: assert property (
    low_power && (data_reg_access || rd_rate || output_reset) |=> !low_power)
    else $error("low power not left on access");

  a_lowpower_enter: assert property (
    !low_power && wr_rate && wr_data[LOW_POWER_BIT] && !wr_data[SOFT_RESET_BIT] |=>
      low_power)
    else $error("low power not entered");

  a_soft_reset_pulse: assert property (
    wr_rate && wr_data[SOFT_RESET_BIT] |=> soft_reset_out ##1 !soft_reset_out)
    else $error("software reset bit not self clearing");

  a_status_answer: assert property (
    rd_rate |=> rd_data_oe == OE_ALL &&
      rd_data == {$past(host_request), $past(transfer_direction),
                  $past(non_dma_mode && exec_phase), $past(command_busy),
                  $past(drive_seek_busy)})
    else $error("status read answered wrongly");

  a_start_track: assert property (
    configure_write |=> write_select_a_start_track == $past(configure_track))
    else $error("precompensation start track not taken");

  a_idle_read_quiet: assert property (
    !rd_rate && !rd_tape |=> rd_data_oe == OE_NONE && rd_data == 8'h00)
    else $error("read lines driven without a read");

  c_enter_low_power: cover property (
    wr_rate && wr_data[LOW_POWER_BIT] ##1 low_power ##[1:20] !low_power);

  c_enhanced_read: cover property (rd_tape && enhanced_mode ##1 rd_data_oe == OE_ALL);

  c_ccr_then_dsr: cover property (ccr_write ##1 wr_rate ##1 data_rate == $past(wr_data[1:0]));

  c_status_request: cover property (rd_rate && host_request && transfer_direction);

  c_write_read_tape: cover property (wr_en && addr == TAPE_MEDIA_ID_OFS ##1 rd_tape);

endmodule

// file: hw/floppy_host_rate_status_pkg.sv
// shared constants for the floppy host rate and status register slice
package floppy_host_rate_status_pkg;

  // register offsets on the host port
  localparam logic [9:0] TAPE_MEDIA_ID_OFS = 10'h3F3;
  localparam logic [9:0] RATE_STATUS_OFS   = 10'h3F4;

  // rate select register layout and hardware reset value
  localparam logic [7:0] RATE_SELECT_RESET = 8'h02;
  localparam int         RATE_LSB          = 0;
  localparam int         WRITE_SELECT_A_LSB       = 2;
  localparam int         LOW_POWER_BIT     = 6;
  localparam int         SOFT_RESET_BIT    = 7;

  // data rate codes
  localparam logic [1:0] RATE_1M   = 2'h3;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;

  // precompensation codes and delays in steps of 41.67 ns
  localparam logic [2:0] WRITE_SELECT_A_DEFAULT  = 3'h0;
  localparam logic [2:0] WRITE_SELECT_A_DISABLED = 3'h7;
  localparam logic [2:0] STEPS_NONE       = 3'h0;
  localparam logic [2:0] STEPS_DEF_1M     = 3'h1;
  localparam logic [2:0] STEPS_DEF_SLOW   = 3'h3;
  localparam int         WRITE_SELECT_A_STEP_PS  = 41670;

  // precompensation starts from this track after hardware reset
  localparam logic [7:0] START_TRACK_RESET = 8'h00;

  // tape/media read enables
  localparam logic [7:0] TAPE_OE_NORMAL = 8'h03;
  localparam logic [7:0] OE_ALL         = 8'hFF;
  localparam logic [7:0] OE_NONE        = 8'h00;

  // config register seven fields
  localparam int CR7_BOOT_LSB = 0;
  localparam int CR7_INV_LSB  = 2;

  typedef enum logic {PWR_RUN, PWR_LOW} power_state_e;

endpackage

// file: verif/floppy_host_model.sv
// host processor model driving the register port of the rate and status slice
`timescale 1ns/100ps
module floppy_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [9:0] addr,
  output logic      [7:0] wr_data,
  output logic            wr_en,
  output logic            rd_en,
  output logic            data_reg_access,
  input  wire logic [7:0] rd_data,
  input  wire logic [7:0] rd_data_oe
);
  initial begin
    addr = 10'h000;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    data_reg_access = 1'b0;
  end

  // released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~v;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [7:0] v, output logic [7:0] oe);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    v = rd_data;
    oe = rd_data_oe;
  endtask

  // write then read back with no gap between the two strobes
  task automatic wr_rd(input logic [9:0] a, input logic [7:0] w, output logic [7:0] v,
                       output logic [7:0] oe);
    @(posedge clk);
    addr <= a;
    wr_data <= w;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~w;
    @(posedge clk);
    v = rd_data;
    oe = rd_data_oe;
  endtask

  // one data register touch
  task automatic dat();
    @(posedge clk);
    data_reg_access <= 1'b1;
    @(posedge clk);
    data_reg_access <= 1'b0;
  endtask
endmodule

// file: verif/floppy_host_rate_status_regs_tb.sv
// self-checking bench for the floppy host rate and status register slice
`timescale 1ns/100ps
module floppy_host_rate_status_regs_tb;
  import floppy_host_rate_status_pkg::*;
  logic       clk, reset_n, enhanced_mode, output_reset, ccr_write, configure_write;
  logic [7:0] config_reg_six, config_reg_seven, configure_track;
  logic [1:0] drive_select, ccr_rate;
  logic [8:0] stat;
  logic       ext0, ext1;
  wire  [9:0] addr;
  wire  [7:0] wr_data, rd_data, rd_data_oe, write_select_a_start_track;
  wire        wr_en, rd_en, data_reg_access, low_power, soft_reset_out;
  wire  [1:0] data_rate, tape_select;
  wire  [2:0] write_select_a_steps;
  wire        p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
  wire        host_request, transfer_direction, non_dma_mode, exec_phase, command_busy;
  wire  [3:0] drive_seek_busy;
  logic [2:0] pc [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  logic [8:0] pat [5] = '{9'h1FF, 9'h0A5, 9'h15A, 9'h000, 9'h118};
  int         err_count = 0;
  int         checks = 0;

  assign {host_request, transfer_direction, non_dma_mode, exec_phase, command_busy,
          drive_seek_busy} = stat;
  // pin level: the block drives it when enabled, the drive side otherwise
  assign p0_in = p0_oe ? p0_out : ext0;
  assign p1_in = p1_oe ? p1_out : ext1;

  floppy_host_model host (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .data_reg_access(data_reg_access), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe));

  floppy_host_rate_status_regs dut (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .enhanced_mode(enhanced_mode),
    .config_reg_six(config_reg_six), .config_reg_seven(config_reg_seven),
    .drive_select(drive_select), .output_reset(output_reset), .ccr_write(ccr_write),
    .ccr_rate(ccr_rate), .configure_write(configure_write),
    .configure_track(configure_track), .drive_seek_busy(drive_seek_busy),
    .command_busy(command_busy), .exec_phase(exec_phase), .non_dma_mode(non_dma_mode),
    .host_request(host_request), .transfer_direction(transfer_direction),
    .data_reg_access(data_reg_access), .rate_pin_0_in(p0_in), .rate_pin_0_out(p0_out),
    .rate_pin_0_oe(p0_oe), .rate_pin_1_in(p1_in), .rate_pin_1_out(p1_out),
    .rate_pin_1_oe(p1_oe), .data_rate(data_rate), .write_select_a_steps(write_select_a_steps),
    .write_select_a_start_track(write_select_a_start_track), .low_power(low_power),
    .soft_reset_out(soft_reset_out), .tape_select(tape_select));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] d, oe;
    reset_n = 1'b0;
    {enhanced_mode, output_reset, ccr_write, configure_write, ext0, ext1} = 6'h01;
    {config_reg_six, config_reg_seven, configure_track} = 24'h000000;
    {drive_select, ccr_rate, stat} = 13'h0000;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({6'h0, data_rate}, {6'h0, RATE_250K});
    chk({5'h0, write_select_a_steps}, {5'h0, STEPS_DEF_SLOW});
    chk(write_select_a_start_track, START_TRACK_RESET);
    chk({6'h0, p1_out, p0_out}, {6'h0, RATE_250K});
    // tape register in normal mode, unmapped place stays silent
    host.wr_rd(TAPE_MEDIA_ID_OFS, 8'hFE, d, oe);
    chk(d, 8'h02);
    chk({6'h0, tape_select}, 8'h02);
    chk(oe, TAPE_OE_NORMAL);
    host.wr(10'h3F5, 8'hFF);
    host.rd(10'h3F5, d, oe);
    chk(d | oe, 8'h00);
    // enhanced mode: pins become inputs, every drive's type pair
    enhanced_mode <= 1'b1;
    config_reg_six <= 8'h1B;
    repeat (3) @(posedge clk);
    chk({6'h0, p1_oe, p0_oe}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      drive_select <= i[1:0];
      config_reg_seven <= {4'h0, i[1:0], ~i[1:0]};
      host.rd(TAPE_MEDIA_ID_OFS, d, oe);
      chk(d, {ext1 ^ i[1], ext0 ^ i[0], 2'(3 - i), ~i[1:0], 2'h2});
    end
    chk(oe, OE_ALL);
    // media bits survive hardware and software reset
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    host.wr(RATE_STATUS_OFS, 8'h82);
    #1;
    chk({7'h0, soft_reset_out}, 8'h01);
    @(posedge clk);
    #1;
    chk({6'h0, soft_reset_out, low_power}, 8'h00);
    host.rd(TAPE_MEDIA_ID_OFS, d, oe);
    chk(d, {~ext1, ~ext0, 6'h00});
    // every rate code against a spread of write_select_a codes
    foreach (pc[j]) for (int r = 0; r < 4; r++) begin
      host.wr(RATE_STATUS_OFS, {3'h0, pc[j], r[1:0]});
      repeat (2) @(posedge clk);
      chk({6'h0, data_rate}, {6'h0, r[1:0]});
      chk({5'h0, write_select_a_steps}, {5'h0, pc[j] == 3'h7 ? 3'h0 :
          pc[j] != 3'h0 ? pc[j] : r == 3 ? 3'h1 : 3'h3});
    end
    // latest writer of the rate wins
    ccr_rate <= 2'h1;
    ccr_write <= 1'b1;
    @(posedge clk);
    ccr_write <= 1'b0;
    configure_track <= 8'h27;
    configure_write <= 1'b1;
    @(posedge clk);
    configure_write <= 1'b0;
    #1;
    chk({6'h0, data_rate}, 8'h01);
    chk(write_select_a_start_track, 8'h27);
    host.wr(RATE_STATUS_OFS, 8'h40);
    #1;
    chk({6'h0, data_rate, low_power}, 8'h01);
    host.dat();
    #1;
    chk({7'h0, low_power}, 8'h00);
    host.wr(RATE_STATUS_OFS, 8'h40);
    host.rd(RATE_STATUS_OFS, d, oe);
    chk({7'h0, low_power}, 8'h00);
    host.wr(RATE_STATUS_OFS, 8'h40);
    output_reset <= 1'b1;
    @(posedge clk);
    output_reset <= 1'b0;
    @(posedge clk);
    chk({7'h0, low_power}, 8'h00);
    chk({6'h0, data_rate}, 8'h00);
    host.wr(RATE_STATUS_OFS, 8'hC0);
    #1;
    chk({6'h0, soft_reset_out, low_power}, 8'h02);
    // status bits from the command engine, bit 5 as non-DMA and execution phase
    foreach (pat[k]) begin
      @(posedge clk);
      stat <= pat[k];
      host.rd(RATE_STATUS_OFS, d, oe);
      chk(d, {pat[k][8:7], pat[k][6] & pat[k][5], pat[k][4:0]});
      chk(oe, OE_ALL);
      // status read before each data byte
      if (d[7]) host.dat();
    end
    give_verdict();
  end
endmodule
